// File: rtl/host_port_map.vh
// Constants for the host bus port of the dual-channel serial controller.
`ifndef HOST_PORT_MAP_VH
`define HOST_PORT_MAP_VH
`define MISC_FUNC_SEL_BIT 2
`define XMIT_TERM_READY_BIT 7
`define ENH_REQ_TIMING_BIT 4
`define REQ_DEASSERT_CYCLES 4
`define SYNC_STAGES 2
`define CLK_MULT_X1 2'b00
`define CLK_MULT_X16 2'b01
`define CLK_MULT_X32 2'b10
`define CLK_MULT_X64 2'b11
`define RX_TX_CLOCK_IN_USE_RX 3'b000
`define RX_TX_CLOCK_IN_USE_TX 3'b001
`define RX_TX_CLOCK_IN_USE_BAUD 3'b010
`define RX_TX_CLOCK_IN_USE_PLL 3'b011
`define RX_TX_CLOCK_IN_USE_XTAL 3'b100
`define TX_RX_CLOCK_IO_SRC_XMIT 2'b00
`define TX_RX_CLOCK_IO_SRC_XTAL 2'b01
`define TX_RX_CLOCK_IO_SRC_BAUD 2'b10
`define TX_RX_CLOCK_IO_SRC_PLL 2'b11
`define BUS_SEPARATE 1'b0
`define BUS_MUXED 1'b1
`endif

// File: rtl/sync_stage.v
// Two-flop level synchroniser for one bus of asynchronous inputs.
`timescale 1ns/1ps
`default_nettype none
module sync_stage #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
	// Clock and reset
	input wire mclk,
	input wire nrst,
	// Data
	input wire [WIDTH-1:0] d,
	output wire [WIDTH-1:0] q
);
	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			meta_reg <= INIT;
			sync_reg <= INIT;
		end else begin
			meta_reg <= d;
			sync_reg <= meta_reg;
		end
	end
	assign q = sync_reg;
endmodule
`default_nettype wire

// File: rtl/host_bus_port.v
// Host bus port: strobes, daisy chain, request pins and clock pin routing.
`timescale 1ns/1ps
`default_nettype none
`include "host_port_map.vh"
////////////////////////////////////////////////////////////////////////////////
module host_bus_port #(
	parameter DW = 8,
	parameter REQ_CYCLES = `REQ_DEASSERT_CYCLES
) (
	// Clock and reset
	input wire mclk,
	input wire nrst,
	// Bus variant select: 0 separate strobes, 1 multiplexed
	input wire bus_mode,
	// Separate-strobe bus
	input wire chip_en_n,
	input wire read_strobe_n,
	input wire store_strobe_n,
	input wire chan_sel,
	input wire data_ctrl_sel,
	// Multiplexed bus
	input wire first_chip_sel_n,
	input wire second_chip_sel,
	input wire data_strobe_n,
	input wire address_strobe_n,
	input wire read_write,
	// Shared data pins
	input wire [DW-1:0] data_in,
	output reg [DW-1:0] data_out,
	output wire data_oe,
	// Register access towards the core
	output reg wr_pulse,
	output reg rd_pulse,
	output reg [DW-1:0] wr_data,
	output reg [DW-1:0] reg_addr,
	output reg access_chan_a,
	output reg access_data,
	input wire [DW-1:0] rd_data,
	output reg bus_reset,
	// Configuration bits from the core
	input wire [DW-1:0] misc_control_register,
	input wire [DW-1:0] transmit_control_register_a,
	input wire [DW-1:0] transmit_control_register_b,
	input wire [DW-1:0] enhancement_register,
	input wire [1:0] wait_req_is_request,
	// Request and wait sources per channel
	input wire [1:0] xmit_dma_req,
	input wire [1:0] wait_req_level,
	output reg [1:0] term_ready_n,
	output reg [1:0] wait_req_out,
	output reg [1:0] wait_req_oe,
	// Interrupt daisy chain
	input wire chain_enable_in,
	output wire chain_enable_out,
	input wire irq_ack_strobe_n,
	input wire irq_pending,
	input wire irq_under_service,
	input wire [DW-1:0] irq_vector,
	output wire irq_out,
	output wire irq_oe,
	// Clock pin routing, two bits per channel where grouped, three for rx_tx_clock_in_use
	input wire [1:0] rx_tx_clock_in_pin,
	input wire [5:0] rx_tx_clock_in_use,
	input wire [3:0] rx_mult_sel,
	input wire [1:0] tx_rx_clock_io_is_output,
	input wire [3:0] tx_rx_clock_io_src,
	input wire [1:0] tx_rx_clock_io_pin_in,
	input wire [1:0] xmit_clk,
	input wire [1:0] baud_clk,
	input wire [1:0] pll_clk,
	input wire [1:0] xtal_clk,
	output reg [1:0] rx_clk,
	output reg [1:0] tx_clk,
	output reg [1:0] baud_src,
	output reg [1:0] pll_src,
	output reg [1:0] xtal_in,
	output reg [6:0] rx_mult,
	output reg [13:0] rx_mult_all,
	output wire [1:0] tx_rx_clock_io_out,
	output wire [1:0] tx_rx_clock_io_oe
);
	////////////////////////////////////////////////////////////////////////////////
	// Synchronised host pins; the master clock owns all internal state.
	wire [10:0] pins_raw;
	wire [10:0] pins_s;
	wire ce_s;
	wire rds_s;
	wire wrs_s;
	wire ab_s;
	wire dc_s;
	wire cs0_s;
	wire cs1_s;
	wire ds_s;
	wire as_s;
	wire rw_s;
	wire ack_s;
	wire [DW-1:0] din_s;
	// Strobes and selects share one synchroniser so they stay aligned to each other.
	assign pins_raw = {
		chip_en_n,
		read_strobe_n,
		store_strobe_n,
		chan_sel,
		data_ctrl_sel,
		first_chip_sel_n,
		second_chip_sel,
		data_strobe_n,
		address_strobe_n,
		read_write,
		irq_ack_strobe_n
	};
	sync_stage #(.WIDTH(11), .INIT(11'h7FF)) u_sync_pins (
		.mclk(mclk),
		.nrst(nrst),
		.d(pins_raw),
		.q(pins_s)
	);
	assign {ce_s, rds_s, wrs_s, ab_s, dc_s, cs0_s, cs1_s, ds_s, as_s, rw_s, ack_s} = pins_s;
	sync_stage #(.WIDTH(DW), .INIT({DW{1'b0}})) u_sync_data (
		.mclk(mclk),
		.nrst(nrst),
		.d(data_in),
		.q(din_s)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Strobe decode for both bus variants.
	reg as_d_reg;
	reg cs0_lat_reg;
	reg rd_act_d_reg;
	reg wr_act_d_reg;
	reg vec_sel_reg;
	wire ack = !ack_s;
	wire sep_rd = !ce_s && !rds_s && wrs_s;
	wire sep_wr = !ce_s && !wrs_s && rds_s;
	wire mux_sel = !cs0_lat_reg && cs1_s;
	wire mux_rd = mux_sel && !ds_s && as_s && rw_s;
	wire mux_wr = mux_sel && !ds_s && as_s && !rw_s;
	wire rd_act = (bus_mode == `BUS_MUXED) ? mux_rd : sep_rd;
	wire wr_act = (bus_mode == `BUS_MUXED) ? mux_wr : sep_wr;
	wire rst_req = (bus_mode == `BUS_MUXED) ? (!as_s && !ds_s) : (!rds_s && !wrs_s);
	wire vec_win = ack && chain_enable_in && irq_pending;
	wire vec_read = vec_win && ((bus_mode == `BUS_MUXED) ? !ds_s : !rds_s);

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			as_d_reg <= 1'b1;
			cs0_lat_reg <= 1'b1;
			rd_act_d_reg <= 1'b0;
			wr_act_d_reg <= 1'b0;
			reg_addr <= {DW{1'b0}};
			access_chan_a <= 1'b0;
			access_data <= 1'b0;
			wr_pulse <= 1'b0;
			rd_pulse <= 1'b0;
			wr_data <= {DW{1'b0}};
			data_out <= {DW{1'b0}};
			bus_reset <= 1'b0;
			vec_sel_reg <= 1'b0;
		end else begin
			as_d_reg <= as_s;
			vec_sel_reg <= vec_win;
			if (bus_mode == `BUS_MUXED && as_s && !as_d_reg) begin
				reg_addr <= din_s;
				cs0_lat_reg <= cs0_s;
			end
			if (bus_mode == `BUS_SEPARATE) begin
				access_chan_a <= ab_s;
				access_data <= dc_s;
			end
			rd_act_d_reg <= rd_act && !ack;
			wr_act_d_reg <= wr_act && !ack;
			wr_pulse <= wr_act && !ack && !wr_act_d_reg && !rst_req;
			rd_pulse <= rd_act && !ack && !rd_act_d_reg && !rst_req;
			if (wr_act && !wr_act_d_reg) begin
				wr_data <= din_s;
			end
			data_out <= vec_win ? irq_vector : rd_data;
			bus_reset <= rst_req;
		end
	end
	// Drivers follow the strobe so the bus is released as soon as it ends.
	// The vector drivers wait one cycle into the window, so the vector is already loaded.
	assign data_oe = (rd_act && !ack) || (vec_read && vec_sel_reg);

	////////////////////////////////////////////////////////////////////////////////
	// Daisy chain and interrupt pin.
	assign chain_enable_out = chain_enable_in && !irq_under_service &&
		!(ack && irq_pending);
	assign irq_out = 1'b0;
	assign irq_oe = irq_pending && !irq_under_service;

	////////////////////////////////////////////////////////////////////////////////
	// Per-channel terminal-ready, wait/request and clock routing.
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
			reg [2:0] hold_reg;
			reg req_reg;
			reg ready_n;
			reg wreq_out;
			reg wreq_oe;
			reg rxc;
			reg txc;
			reg baud_c;
			reg pll_c;
			reg xtal_c;
			reg [6:0] mult;
			wire [DW-1:0] xctl = (ch == 0) ? transmit_control_register_a :
				transmit_control_register_b;
			wire req_mode = misc_control_register[`MISC_FUNC_SEL_BIT];
			wire fast_rel = enhancement_register[`ENH_REQ_TIMING_BIT];
			// Release is delayed so a DMA controller sees a clean edge.
			always @(posedge mclk or negedge nrst) begin
				if (!nrst) begin
					hold_reg <= 3'd0;
					req_reg <= 1'b0;
				end else if (xmit_dma_req[ch]) begin
					req_reg <= 1'b1;
					hold_reg <= REQ_CYCLES[2:0] - 3'd1;
				end else if (hold_reg != 3'd0) begin
					hold_reg <= hold_reg - 3'd1;
				end else begin
					req_reg <= 1'b0;
				end
			end
			// Terminal-ready and wait/request pin drive.
			always @* begin
				if (!req_mode) begin
					ready_n = !xctl[`XMIT_TERM_READY_BIT];
				end else if (fast_rel) begin
					ready_n = !xmit_dma_req[ch];
				end else begin
					ready_n = !(xmit_dma_req[ch] || req_reg);
				end
				if (wait_req_is_request[ch]) begin
					wreq_out = !wait_req_level[ch];
					wreq_oe = 1'b1;
				end else begin
					wreq_out = 1'b0;
					wreq_oe = wait_req_level[ch];
				end
			end
			// Clock pin routing and receive clock multiple.
			always @* begin
				rxc = 1'b0;
				txc = 1'b0;
				baud_c = 1'b0;
				pll_c = 1'b0;
				xtal_c = 1'b0;
				case (rx_tx_clock_in_use[ch*3 +: 3])
					`RX_TX_CLOCK_IN_USE_RX: rxc = rx_tx_clock_in_pin[ch];
					`RX_TX_CLOCK_IN_USE_TX: txc = rx_tx_clock_in_pin[ch];
					`RX_TX_CLOCK_IN_USE_BAUD: baud_c = rx_tx_clock_in_pin[ch];
					`RX_TX_CLOCK_IN_USE_PLL: pll_c = rx_tx_clock_in_pin[ch];
					`RX_TX_CLOCK_IN_USE_XTAL: xtal_c = rx_tx_clock_in_pin[ch];
					default: rxc = rx_tx_clock_in_pin[ch];
				endcase
				if (!tx_rx_clock_io_is_output[ch]) begin
					rxc = rxc | tx_rx_clock_io_pin_in[ch];
					txc = txc | tx_rx_clock_io_pin_in[ch];
				end
				case (rx_mult_sel[ch*2 +: 2])
					`CLK_MULT_X1: mult = 7'd1;
					`CLK_MULT_X16: mult = 7'd16;
					`CLK_MULT_X32: mult = 7'd32;
					default: mult = 7'd64;
				endcase
			end
			assign tx_rx_clock_io_oe[ch] = tx_rx_clock_io_is_output[ch];
			assign tx_rx_clock_io_out[ch] =
				(tx_rx_clock_io_src[ch*2 +: 2] == `TX_RX_CLOCK_IO_SRC_XMIT) ? xmit_clk[ch] :
				(tx_rx_clock_io_src[ch*2 +: 2] == `TX_RX_CLOCK_IO_SRC_XTAL) ? xtal_clk[ch] :
				(tx_rx_clock_io_src[ch*2 +: 2] == `TX_RX_CLOCK_IO_SRC_BAUD) ? baud_clk[ch] : pll_clk[ch];
		end
	endgenerate
	// One process owns each output vector, so no bit has two drivers.
	always @* begin
		term_ready_n = {g_chan[1].ready_n, g_chan[0].ready_n};
		wait_req_out = {g_chan[1].wreq_out, g_chan[0].wreq_out};
		wait_req_oe = {g_chan[1].wreq_oe, g_chan[0].wreq_oe};
		rx_clk = {g_chan[1].rxc, g_chan[0].rxc};
		tx_clk = {g_chan[1].txc, g_chan[0].txc};
		baud_src = {g_chan[1].baud_c, g_chan[0].baud_c};
		pll_src = {g_chan[1].pll_c, g_chan[0].pll_c};
		xtal_in = {g_chan[1].xtal_c, g_chan[0].xtal_c};
		rx_mult_all = {g_chan[1].mult, g_chan[0].mult};
		rx_mult = g_chan[0].mult;
	end
endmodule
`default_nettype wire

// File: tb/host_bus_port_properties.sv
// Checker of the host bus port pins.
`timescale 1ns/1ps
`default_nettype none
module host_bus_port_properties (
	// Clock, reset and strobes
	input wire logic mclk, nrst, bus_mode, chip_en_n, read_strobe_n, store_strobe_n,
	input wire logic irq_ack_strobe_n, wr_pulse, bus_reset, irq_pending, irq_under_service,
	// Configuration and pins
	input wire logic [7:0] misc_control_register, enhancement_register,
	input wire logic [7:0] transmit_control_register_a,
	input wire logic [1:0] wait_req_is_request, xmit_dma_req, wait_req_level, term_ready_n,
	input wire logic [1:0] wait_req_out, wait_req_oe,
	input wire logic chain_enable_in, chain_enable_out,
	input wire logic data_oe,
	input wire logic [7:0] data_out, irq_vector
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	////////////////////
	// Three samples of store give the two-flop synchroniser time to settle.
	sequence s_store;
		!bus_mode && !chip_en_n && read_strobe_n && irq_ack_strobe_n
		&& $fell(store_strobe_n) ##1 !store_strobe_n [*2];
	endsequence
	sequence s_drop;
		misc_control_register[2] && !enhancement_register[4] && $fell(xmit_dma_req[0]);
	endsequence
	property p_ready;
		!misc_control_register[2] |-> term_ready_n[0] == !transmit_control_register_a[7];
	endproperty
	property p_req;
		misc_control_register[2] && xmit_dma_req[0] |-> !term_ready_n[0];
	endproperty
	property p_hold;
		s_drop |-> !term_ready_n[0] [*3] ##3 term_ready_n[0];
	endproperty
	property p_wait;
		!wait_req_is_request[0] |-> !wait_req_out[0] && wait_req_oe[0] == wait_req_level[0];
	endproperty
	property p_chain;
		chain_enable_out |-> chain_enable_in && !irq_under_service;
	endproperty
	property p_block;
		(!irq_ack_strobe_n && irq_pending) [*3] |-> !chain_enable_out;
	endproperty
	property p_write;
		s_store |-> ##[0:2] wr_pulse;
	endproperty
	property p_reset;
		(!bus_mode && !read_strobe_n && !store_strobe_n) [*5] |-> bus_reset;
	endproperty
	property p_vector;
		(!bus_mode && !irq_ack_strobe_n && chain_enable_in && irq_pending && !read_strobe_n) [*4]
		|-> data_oe && data_out == irq_vector;
	endproperty
	a_ready: assert property (p_ready) else $error("ready pin level");
	a_req: assert property (p_req) else $error("request not low");
	a_hold: assert property (p_hold) else $error("request release");
	a_wait: assert property (p_wait) else $error("wait pin drive");
	a_chain: assert property (p_chain) else $error("chain enable high");
	a_block: assert property (p_block) else $error("chain not blocked");
	a_write: assert property (p_write) else $error("no write pulse");
	a_reset: assert property (p_reset) else $error("no bus reset");
	a_vector: assert property (p_vector) else $error("vector not driven");
endmodule
bind host_bus_port host_bus_port_properties u_props (.*);
`default_nettype wire

// File: tb/host_cpu_model.sv
// Host processor model running cycles on both bus variants.
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
	// Clock
	input wire logic mclk,
	// Bus pins towards the port
	output logic chip_en_n, read_strobe_n, store_strobe_n, chan_sel, data_ctrl_sel,
	output logic first_chip_sel_n, second_chip_sel, data_strobe_n, address_strobe_n,
	output logic read_write,
	output logic [7:0] data_in
);
	initial {chip_en_n, read_strobe_n, store_strobe_n, chan_sel, data_ctrl_sel} = 5'h1C;
	initial {first_chip_sel_n, second_chip_sel, data_strobe_n, address_strobe_n} = 4'hB;
	initial {read_write, data_in} = 9'h000;
	////////////////////
	// Entered one tick after an edge; strobes stand five cycles (the mux address strobe three), past the sync delay.
	task sep(input logic rd, st, a, dc, input logic [7:0] d);
		{chip_en_n, chan_sel, data_ctrl_sel, data_in} = {1'b0, a, dc, d};
		{read_strobe_n, store_strobe_n} = {!rd, !st};
		repeat (5) @(posedge mclk);
		#1 {chip_en_n, read_strobe_n, store_strobe_n, data_in} = {3'h7, ~d};
		repeat (2) @(posedge mclk);
		#1;
	endtask
	task mux(input logic [7:0] ad, d);
		{first_chip_sel_n, second_chip_sel, address_strobe_n, read_write} = 4'h4;
		data_in = ad;
		repeat (3) @(posedge mclk);
		#1 address_strobe_n = 1'b1;
		repeat (3) @(posedge mclk);
		#1 {data_in, data_strobe_n} = {d, 1'b0};
		repeat (5) @(posedge mclk);
		#1 {first_chip_sel_n, second_chip_sel, data_strobe_n, data_in} = {3'h5, ~d};
		repeat (2) @(posedge mclk);
		#1;
	endtask
endmodule
`default_nettype wire

// File: tb/host_bus_port_tb.sv
// Self-checking testbench of the host bus port.
`timescale 1ns/1ps
`default_nettype none
module host_bus_port_tb;
	logic mclk, nrst, bus_mode, chain_enable_in, irq_ack_strobe_n, irq_pending, irq_under_service;
	logic [7:0] rd_data, misc_control_register, enhancement_register, irq_vector, seen_wr, seen_out;
	logic [7:0] transmit_control_register_a, transmit_control_register_b;
	logic [1:0] wait_req_is_request, xmit_dma_req, wait_req_level, tx_rx_clock_io_is_output, baud_clk;
	logic [1:0] rx_tx_clock_in_pin;
	logic [5:0] rx_tx_clock_in_use;
	logic [3:0] rx_mult_sel, tx_rx_clock_io_src;
	logic [13:0] wr_cnt, rd_cnt;
	logic seen_a, seen_d, seen_rst;
	int error_cnt, comparisons, i;
	wire logic chip_en_n, read_strobe_n, store_strobe_n, chan_sel, data_ctrl_sel, read_write;
	wire logic first_chip_sel_n, second_chip_sel, data_strobe_n, address_strobe_n, data_oe;
	wire logic wr_pulse, rd_pulse, access_chan_a, access_data, bus_reset, chain_enable_out;
	wire logic irq_out, irq_oe;
	wire logic [7:0] data_in, data_out, wr_data, reg_addr;
	wire logic [1:0] term_ready_n, wait_req_out, wait_req_oe, rx_clk, tx_clk, baud_src, pll_src;
	wire logic [1:0] xtal_in, tx_rx_clock_io_out, tx_rx_clock_io_oe;
	wire logic [6:0] rx_mult;
	wire logic [13:0] rx_mult_all;
	host_bus_port DUT (.*, .tx_rx_clock_io_pin_in(2'h0), .xmit_clk(2'h0), .pll_clk(2'h0), .xtal_clk(2'h0));
	host_cpu_model u_cpu (.*);
	////////////////////
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// The tests need well under 2000 cycles.
	initial begin
		#50000;
		error_cnt++;
		give_verdict;
	end
	always @(posedge mclk) begin
		wr_cnt <= wr_cnt + {13'h0, wr_pulse};
		rd_cnt <= rd_cnt + {13'h0, rd_pulse};
		if (wr_pulse) {seen_wr, seen_a, seen_d} <= {wr_data, access_chan_a, access_data};
		if (data_oe) seen_out <= data_out;
		if (bus_reset) seen_rst <= 1'b1;
	end
	task cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task chk(input logic [31:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task give_verdict;
		if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		{nrst, bus_mode, chain_enable_in, irq_ack_strobe_n, irq_pending, irq_under_service} = 6'h0C;
		{rd_data, misc_control_register, enhancement_register, irq_vector} = 32'h0;
		{transmit_control_register_a, transmit_control_register_b, wr_cnt, rd_cnt} = 44'h0;
		{wait_req_is_request, xmit_dma_req, wait_req_level, tx_rx_clock_io_is_output, baud_clk} = 10'h0;
		{rx_tx_clock_in_pin, rx_tx_clock_in_use, rx_mult_sel, tx_rx_clock_io_src, seen_rst} = 17'h0;
		repeat (5) @(posedge mclk);
		#1 nrst = 1'b1;
		cyc(4);
		transmit_control_register_a = 8'h80;
		cyc(1);
		chk(term_ready_n, 2'h2);
		{transmit_control_register_a, transmit_control_register_b} = 16'h0080;
		cyc(1);
		chk(term_ready_n, 2'h1);
		{misc_control_register, enhancement_register, xmit_dma_req} = 18'h0_1043;
		cyc(1);
		chk(term_ready_n, 2'h0);
		xmit_dma_req = 2'h0;
		cyc(1);
		chk(term_ready_n, 2'h3);
		{enhancement_register, xmit_dma_req} = 10'h003;
		cyc(2);
		xmit_dma_req = 2'h0;
		cyc(2);
		chk(term_ready_n, 2'h0);
		cyc(4);
		chk(term_ready_n, 2'h3);
		{misc_control_register, wait_req_level} = 10'h001;
		cyc(1);
		chk({wait_req_out, wait_req_oe}, 4'h1);
		wait_req_is_request = 2'h3;
		cyc(1);
		chk({wait_req_out, wait_req_oe}, 4'hB);
		for (i = 0; i < 16; i++) begin
			{chain_enable_in, irq_under_service, irq_pending, irq_ack_strobe_n} = i[3:0];
			cyc(4);
			chk({chain_enable_out, irq_oe, irq_out},
				{i[3] & !i[2] & (i[0] | !i[1]), i[1] & !i[2], 1'b0});
		end
		{chain_enable_in, irq_under_service, irq_pending, irq_ack_strobe_n} = 4'h9;
		for (i = 0; i < 4; i++) begin
			u_cpu.sep(0, 1, i[1], i[0], 8'hA0 + i[7:0]);
			chk({seen_wr, seen_a, seen_d, wr_cnt},
				{8'hA0 + i[7:0], i[1:0], i[13:0] + 14'h1});
		end
		rd_data = 8'h3C;
		u_cpu.sep(1, 0, 1, 0, 8'h00);
		chk({seen_out, rd_cnt}, {8'h3C, 14'h1});
		{irq_vector, irq_ack_strobe_n, irq_pending} = 10'h169;
		cyc(4);
		u_cpu.sep(1, 0, 0, 0, 8'h00);
		chk({seen_out, rd_cnt}, {8'h5A, 14'h1});
		{irq_ack_strobe_n, irq_pending} = 2'h2;
		cyc(4);
		u_cpu.sep(1, 1, 0, 0, 8'h00);
		chk({seen_rst, wr_cnt, rd_cnt}, {1'b1, 14'h4, 14'h1});
		bus_mode = 1'b1;
		cyc(3);
		u_cpu.mux(8'h27, 8'h6B);
		chk({reg_addr, seen_wr, wr_cnt}, {8'h27, 8'h6B, 14'h5});
		for (i = 0; i < 4; i++) begin
			rx_mult_sel = {i[1:0], i[1:0]};
			cyc(3);
			chk(rx_mult_all, {2{i == 0 ? 7'h01 : 7'h08 << i}});
		end
		{rx_tx_clock_in_use, tx_rx_clock_io_src, tx_rx_clock_io_is_output, rx_tx_clock_in_pin, baud_clk} = 16'h8895;
		cyc(3);
		chk({baud_src[0], tx_rx_clock_io_out[0], tx_rx_clock_io_oe[0]}, 3'h7);
		give_verdict;
	end
endmodule
`default_nettype wire
